/* bco_pkg.sv */
// Function
// - Unconditional jump loads address into program counter
// - Jump when sign flag clear
// - Jump when zero flag clear
// - Jump when sign flag set
// - Jump when zero flag set
// - Taken jump resumes fetch at target
// - Config load writes constant to selected register
// - Config load: opcode nibble, index nibble, constant
// - Push copies fuzzy result onto stack top
// - Logic result zero sets zero flag, else clears
// - Fuzzy AND/OR combine stack entries into result
package bco_pkg;

    // ========================================
    // Opcode patterns (upper nibble of first byte)
    localparam logic [3:0] OP_JUMP_ALWAYS     = 4'h a;
    localparam logic [3:0] OP_JUMP_NOT_NEG    = 4'h f;
    localparam logic [3:0] OP_JUMP_NONZERO    = 4'h d;
    localparam logic [3:0] OP_JUMP_NEG        = 4'h e;
    localparam logic [3:0] OP_JUMP_EQ_ZERO    = 4'h c;
    localparam logic [3:0] OP_LOAD_CONST_CFG  = 4'h b;

    // ========================================
    // One-byte operations (whole first byte, 5 cycles)
    localparam logic [7:0] OP_PUSH_FUZZY      = 8'h 01;
    localparam logic [7:0] OP_FUZZY_AND       = 8'h 02;
    localparam logic [7:0] OP_FUZZY_OR        = 8'h 03;
    localparam logic [7:0] OP_LOGIC_AND       = 8'h 04;

    // ========================================
    // Widths and geometry
    localparam int PC_W      = 11;
    localparam int CFG_REGS  = 16;
    localparam int STACK_D   = 2;

    // ========================================
    // Timing
    localparam logic [2:0] CYC_TWO_BYTE = 3'h 6;
    localparam logic [2:0] CYC_ONE_BYTE = 3'h 5;

    // ========================================
    // Reset values
    localparam logic [PC_W-1:0] PC_RST   = 11'h 000;
    localparam logic [7:0]      CFG_RST  = 8'h 00;
    // Arbitrary mid-scale K out of reset; the stack itself clears to zero
    localparam logic [7:0]      FUZ_RST  = 8'h 80;

    typedef enum logic [1:0] {
        BCO_FETCH1,
        BCO_FETCH2,
        BCO_WAIT
    } bco_state_t;

endpackage

/* bco_exec_if.sv */
`timescale 1ns/1ps
// ========================================
// Decoded instruction handed from decoder to executor
interface bco_exec_if;
    import bco_pkg::*;
    logic             go;
    logic [7:0]       byte1;
    logic [7:0]       byte2;
    logic             take_jump;
    logic             cfg_we;
    logic             push_k;
    logic             fuzzy_and;
    logic             fuzzy_or;
    logic             logic_and;
    logic [PC_W-1:0]  target;

    modport decoder (input go, byte1, byte2,
                     output take_jump, cfg_we, push_k, fuzzy_and,
                            fuzzy_or, logic_and, target);
    modport control (output go, byte1, byte2,
                     input take_jump, cfg_we, push_k, fuzzy_and,
                           fuzzy_or, logic_and, target);
endinterface

/* bco_decode.sv */
`timescale 1ns/1ps
module bco_decode
    import bco_pkg::*;
(
    input  wire logic zero_flag,
    input  wire logic sign_flag,
    bco_exec_if.decoder ex
);
    logic [3:0] op;

    always_comb begin
        op           = ex.byte1[7:4];
        ex.take_jump = 1'b0;
        ex.cfg_we    = 1'b0;
        ex.push_k    = 1'b0;
        ex.fuzzy_and = 1'b0;
        ex.fuzzy_or  = 1'b0;
        ex.logic_and = 1'b0;
        // Address is 11 bits: three low opcode-byte bits plus operand byte
        ex.target    = {ex.byte1[2:0], ex.byte2};
        if (ex.go) begin
            unique case (op)
                OP_JUMP_ALWAYS:    ex.take_jump = 1'b1;
                OP_JUMP_NOT_NEG:   ex.take_jump = !sign_flag;
                OP_JUMP_NONZERO:   ex.take_jump = !zero_flag;
                OP_JUMP_NEG:       ex.take_jump = sign_flag;
                OP_JUMP_EQ_ZERO:   ex.take_jump = zero_flag;
                OP_LOAD_CONST_CFG: ex.cfg_we    = 1'b1;
                default: begin
                    ex.push_k    = (ex.byte1 == OP_PUSH_FUZZY);
                    ex.fuzzy_and = (ex.byte1 == OP_FUZZY_AND);
                    ex.fuzzy_or  = (ex.byte1 == OP_FUZZY_OR);
                    ex.logic_and = (ex.byte1 == OP_LOGIC_AND);
                end
            endcase
        end
    end
endmodule

/* bco_core.sv */
`timescale 1ns/1ps
module bco_core
    import bco_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [7:0]       prog_data,
    input  wire logic [7:0]       logic_opa,
    input  wire logic [7:0]       logic_opb,
    output logic [PC_W-1:0]       prog_addr,
    output logic                  zero_flag,
    output logic                  sign_flag,
    output logic [7:0]            fuzzy_result,
    output logic [7:0]            fuzzy_stack_top,
    output logic [7:0]            fuzzy_stack_next,
    output logic [CFG_REGS*8-1:0] config_bank,
    output logic                  instr_done
);
    typedef struct packed {
        bco_state_t        st;
        logic [PC_W-1:0]   pc;
        logic [7:0]        b1;
        logic [7:0]        b2;
        logic [2:0]        cnt;
        logic              z;
        logic              s;
        logic [7:0]        k;
        logic [STACK_D-1:0][7:0]  stk;
        logic [CFG_REGS-1:0][7:0] cfg;
        logic              done;
    } bco_core_t;

    bco_core_t  state_reg;
    bco_core_t  state_next;
    bco_exec_if ex ();

    function automatic logic [7:0] bco_min(input logic [7:0] a,
                                           input logic [7:0] b);
        bco_min = (a < b) ? a : b;
    endfunction

    function automatic logic [7:0] bco_max(input logic [7:0] a,
                                           input logic [7:0] b);
        bco_max = (a > b) ? a : b;
    endfunction

    // Executes on the last cycle, when both bytes are held
    assign ex.go    = (state_reg.st == BCO_WAIT) && (state_reg.cnt == 3'h 1);
    assign ex.byte1 = state_reg.b1;
    assign ex.byte2 = state_reg.b2;

    bco_decode u_decode (
        .zero_flag (state_reg.z),
        .sign_flag (state_reg.s),
        .ex        (ex.decoder)
    );

    // ========================================
    // Sequencer
    always_comb begin
        logic two_byte;
        logic [7:0] and_res;
        two_byte   = 1'b0;
        and_res    = logic_opa & logic_opb;
        state_next = state_reg;
        state_next.done = 1'b0;
        unique case (state_reg.st)
            BCO_FETCH1: begin
                state_next.b1 = prog_data;
                state_next.pc = state_reg.pc + 11'h 001;
                two_byte = (prog_data[7:4] >= OP_LOAD_CONST_CFG) ||
                           (prog_data[7:4] == OP_JUMP_ALWAYS);
                if (two_byte) begin
                    state_next.st = BCO_FETCH2;
                end else begin
                    state_next.b2  = 8'h 00;
                    state_next.st  = BCO_WAIT;
                    state_next.cnt = CYC_ONE_BYTE - 3'h 1;
                end
            end
            BCO_FETCH2: begin
                // Two bytes, six cycles in total
                state_next.b2  = prog_data;
                state_next.pc  = state_reg.pc + 11'h 001;
                state_next.st  = BCO_WAIT;
                state_next.cnt = CYC_TWO_BYTE - 3'h 2;
            end
            BCO_WAIT: begin
                state_next.cnt = state_reg.cnt - 3'h 1;
                if (state_reg.cnt == 3'h 1) begin
                    state_next.st   = BCO_FETCH1;
                    state_next.done = 1'b1;
                    // Not-taken jumps fall through to the next byte
                    if (ex.take_jump) begin
                        state_next.pc = ex.target;
                    end
                    if (ex.cfg_we) begin
                        // Flags untouched here
                        state_next.cfg[state_reg.b1[3:0]] =
                            state_reg.b2;
                    end
                    if (ex.push_k) begin
                        state_next.stk[1] = state_reg.stk[0];
                        state_next.stk[0] = state_reg.k;
                    end
                    // Fuzzy AND is minimum, OR is maximum
                    if (ex.fuzzy_and) begin
                        state_next.k = bco_min(state_reg.stk[0],
                                               state_reg.stk[1]);
                    end
                    if (ex.fuzzy_or) begin
                        state_next.k = bco_max(state_reg.stk[0],
                                               state_reg.stk[1]);
                    end
                    if (ex.logic_and) begin
                        state_next.z = (and_res == 8'h 00);
                    end
                end
            end
            default: state_next.st = BCO_FETCH1;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= '0;
            state_reg.st   <= BCO_FETCH1;
            state_reg.pc   <= PC_RST;
            state_reg.k    <= FUZ_RST;
            state_reg.cfg  <= {CFG_REGS{CFG_RST}};
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign prog_addr        = state_reg.pc;
    assign zero_flag        = state_reg.z;
    assign sign_flag        = state_reg.s;
    assign fuzzy_result     = state_reg.k;
    assign fuzzy_stack_top  = state_reg.stk[0];
    assign fuzzy_stack_next = state_reg.stk[1];
    assign config_bank      = state_reg.cfg;
    assign instr_done       = state_reg.done;
endmodule

/* bco_core_properties.sv */
`timescale 1ns/1ps
// ========================================
// Port-level checks of the branch and config-load core
module bco_core_chk
    import bco_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  clk_en,
    input wire logic [PC_W-1:0]       prog_addr,
    input wire logic                  zero_flag,
    input wire logic                  sign_flag,
    input wire logic [7:0]            fuzzy_result,
    input wire logic [7:0]            fuzzy_stack_top,
    input wire logic [7:0]            fuzzy_stack_next,
    input wire logic [CFG_REGS*8-1:0] config_bank,
    input wire logic                  instr_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Shortest instruction is five cycles, so done never comes sooner
    property p_done_gap; instr_done && clk_en |=> !instr_done [*4]; endproperty
    a_done_gap: assert property (p_done_gap) else $error("done too soon");
    property p_sign_hold; $stable(sign_flag); endproperty
    a_sign_hold: assert property (p_sign_hold) else $error("sign moved");
    property p_zero_done; $changed(zero_flag) |-> instr_done; endproperty
    a_zero_done: assert property (p_zero_done) else $error("zero early");
    property p_freeze; !clk_en |=> $stable(prog_addr) && $stable(config_bank);
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved while frozen");
    property p_cfg_done; $changed(config_bank) |-> instr_done; endproperty
    a_cfg_done: assert property (p_cfg_done) else $error("config early");
    property p_fuz_done; $changed(fuzzy_result) |-> instr_done; endproperty
    a_fuz_done: assert property (p_fuz_done) else $error("result early");
    property p_push_shift; $changed(fuzzy_stack_next) |->
        fuzzy_stack_next == $past(fuzzy_stack_top); endproperty
    a_push_shift: assert property (p_push_shift) else $error("bad shift");
    property p_pc_step; $changed(prog_addr) && !instr_done |->
        prog_addr == PC_W'($past(prog_addr) + 1); endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc jumped early");
endmodule

bind bco_core bco_core_chk bco_core_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .prog_addr(prog_addr), .zero_flag(zero_flag),
    .sign_flag(sign_flag), .fuzzy_result(fuzzy_result),
    .fuzzy_stack_top(fuzzy_stack_top), .fuzzy_stack_next(fuzzy_stack_next),
    .config_bank(config_bank), .instr_done(instr_done));

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import bco_pkg::*;
    logic                  sys_clk, rst_n, clk_en, done, zf, sf;
    logic [7:0]            opa, opb, fres, top, nxt;
    logic [7:0]            mem [0:2047];
    logic [PC_W-1:0]       pc;
    logic [CFG_REGS*8-1:0] cfg;
    int                    bad_count, total_checks;
    // Program image as {address, byte}
    logic [19:0] prog [22] = '{20'h0_0004, 20'h0_01c0, 20'h0_0210, 20'h0_10d0,
        20'h0_1120, 20'h0_12f0, 20'h0_1330, 20'h0_30e0, 20'h0_3140, 20'h0_32b5,
        20'h0_332b, 20'h0_3401, 20'h0_3502, 20'h0_3603, 20'h0_3701, 20'h0_3804,
        20'h0_39d0, 20'h0_3a50, 20'h0_50c0, 20'h0_5160, 20'h0_52a7,
        20'h0_53ff};
    bco_core bco_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .prog_data(mem[pc]), .logic_opa(opa), .logic_opb(opb), .prog_addr(pc),
        .zero_flag(zf), .sign_flag(sf), .fuzzy_result(fres),
        .fuzzy_stack_top(top), .fuzzy_stack_next(nxt), .config_bank(cfg),
        .instr_done(done));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ========================================
    // Shared tasks
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    // Stall holds clk_en low for st edges after the first one
    task automatic exec(input logic [10:0] npc, input int cyc, input int st);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            clk_en <= (n >= st);
            n++;
            #1;
        end while (done !== 1'b1 && n < 30);
        chk(n, cyc);
        chk(pc, npc);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic t_zero_path();
        exec(11'h001, 5, 0);
        chk(zf, 1'b1);
        exec(11'h010, 6, 0);
        exec(11'h012, 6, 0);
        exec(11'h030, 6, 0);
        exec(11'h032, 6, 0);
        chk({zf, sf}, 2'b10);
    endtask
    task automatic t_config_push();
        exec(11'h034, 9, 3);
        chk(cfg, 128'h2b << 40);
        exec(11'h035, 5, 0);
        chk({top, nxt}, 16'h8000);
        chk(fres, 8'h80);
        // Fuzzy AND is the minimum, OR the maximum of the two entries
        exec(11'h036, 5, 0);
        chk(fres, 8'h00);
        exec(11'h037, 5, 0);
        chk(fres, 8'h80);
        exec(11'h038, 5, 0);
        chk({top, nxt}, 16'h8080);
    endtask
    task automatic t_nonzero_path();
        opa <= 8'h81;
        opb <= 8'h81;
        exec(11'h039, 5, 0);
        chk(zf, 1'b0);
        exec(11'h050, 6, 0);
        exec(11'h052, 6, 0);
        exec(11'h7ff, 6, 0);
        chk(cfg, 128'h2b << 40);
    endtask
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        opa = 8'h0f;
        opb = 8'hf0;
        foreach (mem[i]) mem[i] = 8'h00;
        foreach (prog[i]) mem[prog[i][18:8]] = prog[i][7:0];
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_zero_path();
        t_config_push();
        t_nonzero_path();
        stop_test();
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end
endmodule
